// ---- vgr_pkg.sv ----
// Package with port map, field positions and constants of the video general register block
package vgr_pkg;
  localparam logic [15:0] PORT_ATTR_IDX    = 16'h03C0;
  localparam logic [15:0] PORT_ATTR_RD     = 16'h03C1;
  localparam logic [15:0] PORT_MISC_WR     = 16'h03C2;
  localparam logic [15:0] PORT_STAT0       = 16'h03C2;
  localparam logic [15:0] PORT_SUBSYS      = 16'h03C3;
  localparam logic [15:0] PORT_PAL_MASK    = 16'h03C6;
  localparam logic [15:0] PORT_PAL_RD_IDX  = 16'h03C7;
  localparam logic [15:0] PORT_PAL_WR_IDX  = 16'h03C8;
  localparam logic [15:0] PORT_PAL_DATA    = 16'h03C9;
  localparam logic [15:0] PORT_FEAT_RD     = 16'h03CA;
  localparam logic [15:0] PORT_MISC_RD     = 16'h03CC;
  localparam logic [15:0] PORT_EXT_IDX     = 16'h03DE;
  localparam logic [15:0] PORT_EXT_DATA    = 16'h03DF;
  localparam logic [15:0] PORT_MONO_BASE   = 16'h03B0;
  localparam logic [15:0] PORT_COLR_BASE   = 16'h03D0;
  localparam logic [3:0]  OFS_TIMING_IDX   = 4'h4;
  localparam logic [3:0]  OFS_TIMING_DATA  = 4'h5;
  localparam logic [3:0]  OFS_STAT1        = 4'hA;
  localparam logic [15:0] TRAP_LO          = 16'h03D8;
  localparam logic [15:0] TRAP_HI          = 16'h03D9;
  // Field positions
  localparam int MISC_VPOL     = 7;
  localparam int MISC_HPOL     = 6;
  localparam int MISC_PAGE     = 5;
  localparam int MISC_CLK_HI   = 3;
  localparam int MISC_CLK_LO   = 2;
  localparam int MISC_MEM_EN   = 1;
  localparam int MISC_COLOR    = 0;
  localparam int ST0_IRQ       = 7;
  localparam int ST0_SENSE     = 4;
  localparam int ST1_DIAG_HI   = 5;
  localparam int ST1_DIAG_LO   = 4;
  localparam int ST1_VRET      = 3;
  localparam int ST1_RET       = 0;
  localparam int FEAT_VSYNC_OR = 3;
  localparam int SUB_EN        = 0;
  localparam int EXT_CLK_HI    = 0;
  localparam logic [7:0] EXT_IDX_CLK   = 8'h00;
  localparam logic [7:0] EXT_IDX_PLANE = 8'h01;
  localparam logic [7:0] EXT_IDX_LINE  = 8'h02;
  localparam logic [7:0] EXT_IDX_PAN   = 8'h03;
  localparam logic [7:0] EXT_IDX_LATCH = 8'h04;
  localparam logic [7:0] RESET_BYTE    = 8'h00;
  localparam logic [7:0] REFRESH_STEP  = 8'h01;
  // Vertical size codes
  localparam logic [1:0] VSIZE_RSVD = 2'b00;
  localparam logic [1:0] VSIZE_400  = 2'b01;
  localparam logic [1:0] VSIZE_350  = 2'b10;
  localparam logic [1:0] VSIZE_480  = 2'b11;
  // Dot clock codes
  localparam logic [2:0] CLK_25M  = 3'b000;
  localparam logic [2:0] CLK_28M  = 3'b001;
  localparam logic [2:0] CLK_EXT  = 3'b010;
  localparam logic [2:0] CLK_14M  = 3'b100;
  localparam logic [2:0] CLK_16M  = 3'b101;
  localparam logic [2:0] CLK_32M  = 3'b111;
  typedef enum logic [2:0] {
    VGR_IDLE  = 3'b000,
    VGR_ADDR  = 3'b001,
    VGR_DATA  = 3'b010,
    VGR_DONE  = 3'b011,
    VGR_FETCH = 3'b100
  } vgr_mem_e;
endpackage : vgr_pkg

// ---- vgr_top.sv ----
// General register group with host port decode and display memory sequencer
`timescale 1ns/10ps
module vgr_top (
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  input  wire logic        clk_en_in,
  input  wire logic [15:0] io_addr_in,
  input  wire logic        io_rd_in,
  input  wire logic        io_wr_in,
  input  wire logic        mem_rd_in,
  input  wire logic        mem_wr_in,
  input  wire logic [15:0] mem_addr_in,
  input  wire logic [7:0]  host_data_in,
  input  wire logic        sense_in,
  input  wire logic        vretrace_in,
  input  wire logic        hretrace_in,
  input  wire logic        vdisp_en_in,
  input  wire logic        vsync_raw_in,
  input  wire logic        retrace_event_in,
  input  wire logic        retrace_clear_in,
  input  wire logic [7:0]  color_in,
  input  wire logic [7:0]  scan_line_in,
  input  wire logic [15:0] disp_addr_in,
  input  wire logic        disp_fetch_req_in,
  input  wire logic [7:0]  md_in,
  output logic [7:0]       host_data_out,
  output logic             host_ready_out,
  output logic             nmi_n_out,
  output logic             dir_to_host_out,
  output logic [3:0]       ras_n_out,
  output logic             cas_n_out,
  output logic             we_n_out,
  output logic             oe_n_out,
  output logic [7:0]       md_out,
  output logic             md_oe_out,
  output logic             pal_rd_n_out,
  output logic             pal_wr_n_out,
  output logic             timing_sel_out,
  output logic [1:0]       vsize_out,
  output logic             page_hi_out,
  output logic [2:0]       clk_sel_out,
  output logic             vsync_out,
  output logic             retrace_irq_n_out,
  output logic [3:0]       pan_out,
  output logic [7:0]       fetch_data_out
);
  import vgr_pkg::*;
  default clocking cb_main @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  logic [7:0]  misc_output_control;
  logic [7:0]  subsystem_enable;
  logic [7:0]  feature_ctl;
  logic [7:0]  palette_pixel_mask;
  logic [7:0]  palette_read_index;
  logic [7:0]  palette_write_index;
  logic [7:0]  attribute_index_port;
  logic [7:0]  extended_index_port;
  logic [7:0]  ext_clk;
  logic [7:0]  plane_enable;
  logic [7:0]  line_compare;
  logic [7:0]  pan_setting;
  logic [7:0]  proc_latch;
  logic [7:0]  refresh_count;
  logic        irq_pend;
  logic [2:0]  sense_sync;
  logic        sense_level;
  logic        io_rd_q;
  logic        io_wr_q;
  logic        mem_busy;
  logic        cpu_write;
  logic [15:0] cpu_addr;
  logic [7:0]  cpu_wdata;
  logic        grant_cpu;
  logic        prefer_cpu;
  vgr_mem_e    mem_state;
  vgr_mem_e    next_mem_state;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] p);
    hit = (a == p);
  endfunction : hit

  function automatic logic [15:0] emu_port(input logic color, input logic [3:0] ofs);
    emu_port = (color ? PORT_COLR_BASE : PORT_MONO_BASE) | {12'h000, ofs};
  endfunction : emu_port

  logic dec_en;
  logic rd_go;
  logic wr_go;
  logic mem_go;
  assign dec_en = subsystem_enable[SUB_EN];
  assign rd_go  = io_rd_in && !io_rd_q && dec_en;
  assign wr_go  = io_wr_in && !io_wr_q && dec_en;
  assign mem_go = (mem_rd_in || mem_wr_in) && !mem_busy && dec_en
                  && misc_output_control[MISC_MEM_EN];

  // Edge detect so a long command strobe counts once
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      io_rd_q <= 1'b0;
      io_wr_q <= 1'b0;
    end else if (clk_en_in) begin
      io_rd_q <= io_rd_in;
      io_wr_q <= io_wr_in;
    end
  end

  // Monitor sense crosses from the pin
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sense_sync  <= 3'b000;
      sense_level <= 1'b0;
    end else if (clk_en_in) begin
      sense_sync <= {sense_sync[1:0], sense_in};
      if (sense_sync[2] == sense_sync[1]) begin
        sense_level <= sense_sync[2];
      end
    end
  end

  // Register writes, one byte each
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      misc_output_control  <= RESET_BYTE;
      subsystem_enable     <= 8'h01;
      feature_ctl          <= RESET_BYTE;
      palette_pixel_mask   <= 8'hFF;
      palette_read_index   <= RESET_BYTE;
      palette_write_index  <= RESET_BYTE;
      attribute_index_port <= RESET_BYTE;
      extended_index_port  <= RESET_BYTE;
      ext_clk              <= RESET_BYTE;
      plane_enable         <= RESET_BYTE;
      line_compare         <= 8'hFF;
      pan_setting          <= RESET_BYTE;
    end else if (clk_en_in && io_wr_in && !io_wr_q) begin
      if (hit(io_addr_in, PORT_SUBSYS)) begin
        subsystem_enable <= {7'h00, host_data_in[SUB_EN]};
      end
      if (dec_en) begin
        if (hit(io_addr_in, PORT_MISC_WR)) begin
          misc_output_control <= host_data_in;
        end
        if (hit(io_addr_in, emu_port(misc_output_control[MISC_COLOR], OFS_STAT1))) begin
          feature_ctl <= {4'h0, host_data_in[FEAT_VSYNC_OR], 3'b000};
        end
        if (hit(io_addr_in, PORT_PAL_MASK)) begin
          palette_pixel_mask <= host_data_in;
        end
        if (hit(io_addr_in, PORT_PAL_RD_IDX)) begin
          palette_read_index <= host_data_in;
        end
        if (hit(io_addr_in, PORT_PAL_WR_IDX)) begin
          palette_write_index <= host_data_in;
        end
        if (hit(io_addr_in, PORT_ATTR_IDX)) begin
          attribute_index_port <= host_data_in;
        end
        if (hit(io_addr_in, PORT_EXT_IDX)) begin
          extended_index_port <= host_data_in;
        end
        if (hit(io_addr_in, PORT_EXT_DATA)) begin
          case (extended_index_port)
            EXT_IDX_CLK:   ext_clk      <= host_data_in;
            EXT_IDX_PLANE: plane_enable <= host_data_in;
            EXT_IDX_LINE:  line_compare <= host_data_in;
            EXT_IDX_PAN:   pan_setting  <= host_data_in;
            default:       ext_clk      <= ext_clk;
          endcase
        end
      end
    end
  end

  // Pending retrace flag; a new event wins over a clear
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_pend <= 1'b0;
    end else if (clk_en_in) begin
      if (retrace_event_in) begin
        irq_pend <= 1'b1;
      end else if (retrace_clear_in) begin
        irq_pend <= 1'b0;
      end
    end
  end

  logic [1:0] diag_pair;
  always_comb begin
    case (plane_enable[5:4])
      2'b00:   diag_pair = {color_in[2], color_in[0]};
      2'b01:   diag_pair = {color_in[5], color_in[4]};
      2'b10:   diag_pair = {color_in[3], color_in[1]};
      default: diag_pair = {color_in[7], color_in[6]};
    endcase
  end

  logic [7:0] rd_byte;
  logic       trap_hit;
  always_comb begin
    rd_byte = RESET_BYTE;
    if (hit(io_addr_in, PORT_STAT0)) begin
      rd_byte[ST0_IRQ]   = irq_pend;
      rd_byte[ST0_SENSE] = sense_level;
    end else if (hit(io_addr_in, PORT_MISC_RD)) begin
      rd_byte = misc_output_control;
    end else if (hit(io_addr_in, emu_port(misc_output_control[MISC_COLOR], OFS_STAT1))) begin
      rd_byte[ST1_DIAG_HI] = diag_pair[1];
      rd_byte[ST1_DIAG_LO] = diag_pair[0];
      rd_byte[ST1_VRET]    = vretrace_in;
      rd_byte[ST1_RET]     = vretrace_in || hretrace_in;
    end else if (hit(io_addr_in, PORT_FEAT_RD)) begin
      rd_byte = feature_ctl;
    end else if (hit(io_addr_in, PORT_SUBSYS)) begin
      rd_byte = subsystem_enable;
    end else if (hit(io_addr_in, PORT_PAL_MASK)) begin
      rd_byte = palette_pixel_mask;
    end else if (hit(io_addr_in, PORT_PAL_WR_IDX)) begin
      rd_byte = palette_write_index;
    end else if (hit(io_addr_in, PORT_ATTR_IDX)) begin
      rd_byte = attribute_index_port;
    end else if (hit(io_addr_in, PORT_EXT_IDX)) begin
      rd_byte = extended_index_port;
    end else if (hit(io_addr_in, PORT_EXT_DATA)) begin
      case (extended_index_port)
        EXT_IDX_CLK:   rd_byte = ext_clk;
        EXT_IDX_PLANE: rd_byte = plane_enable;
        EXT_IDX_LINE:  rd_byte = line_compare;
        EXT_IDX_PAN:   rd_byte = pan_setting;
        EXT_IDX_LATCH: rd_byte = proc_latch;
        default:       rd_byte = RESET_BYTE;
      endcase
    end
  end
  // Only the fixed ports TRAP_LO and TRAP_HI trap, whatever the emulation mode
  assign trap_hit = hit(io_addr_in, TRAP_LO) || hit(io_addr_in, TRAP_HI);

  // Host side outputs
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      host_data_out   <= RESET_BYTE;
      nmi_n_out       <= 1'b1;
      dir_to_host_out <= 1'b0;
      pal_rd_n_out    <= 1'b1;
      pal_wr_n_out    <= 1'b1;
      timing_sel_out  <= 1'b0;
    end else if (clk_en_in) begin
      if (rd_go) begin
        host_data_out <= rd_byte;
      end else if (mem_state == VGR_DONE && !cpu_write) begin
        host_data_out <= proc_latch;
      end
      nmi_n_out <= !((rd_go || wr_go) && trap_hit);
      dir_to_host_out <= (io_rd_in || mem_rd_in) && dec_en;
      pal_rd_n_out <= !(rd_go && (hit(io_addr_in, PORT_PAL_DATA)
                                  || hit(io_addr_in, PORT_PAL_RD_IDX)));
      pal_wr_n_out <= !(wr_go && (hit(io_addr_in, PORT_PAL_DATA)
                                  || hit(io_addr_in, PORT_PAL_RD_IDX)
                                  || hit(io_addr_in, PORT_PAL_WR_IDX)));
      timing_sel_out <= (rd_go || wr_go) &&
        (hit(io_addr_in, emu_port(misc_output_control[MISC_COLOR], OFS_TIMING_IDX)) ||
         hit(io_addr_in, emu_port(misc_output_control[MISC_COLOR], OFS_TIMING_DATA)));
    end
  end

  // Mode outputs
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      vsize_out         <= VSIZE_RSVD;
      page_hi_out       <= 1'b0;
      clk_sel_out       <= CLK_25M;
      vsync_out         <= 1'b0;
      retrace_irq_n_out <= 1'b1;
      pan_out           <= 4'h0;
    end else if (clk_en_in) begin
      vsize_out   <= {misc_output_control[MISC_VPOL], misc_output_control[MISC_HPOL]};
      page_hi_out <= misc_output_control[MISC_PAGE];
      clk_sel_out <= {ext_clk[EXT_CLK_HI], misc_output_control[MISC_CLK_HI],
                      misc_output_control[MISC_CLK_LO]};
      vsync_out <= feature_ctl[FEAT_VSYNC_OR] ? (vsync_raw_in || vdisp_en_in)
                                              : vsync_raw_in;
      retrace_irq_n_out <= !irq_pend;
      // Pan stops at the compare line so the lower window stays put
      pan_out <= (scan_line_in < line_compare) ? pan_setting[3:0] : 4'h0;
    end
  end

  // Memory sequencer: host and display fetch alternate
  always_comb begin
    next_mem_state = mem_state;
    case (mem_state)
      VGR_IDLE:  next_mem_state = (mem_go || disp_fetch_req_in) ? VGR_ADDR : VGR_IDLE;
      VGR_ADDR:  next_mem_state = VGR_DATA;
      VGR_DATA:  next_mem_state = grant_cpu ? VGR_DONE : VGR_FETCH;
      VGR_DONE:  next_mem_state = VGR_IDLE;
      VGR_FETCH: next_mem_state = VGR_IDLE;
      default:   next_mem_state = VGR_IDLE;
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mem_state     <= VGR_IDLE;
      mem_busy      <= 1'b0;
      grant_cpu     <= 1'b0;
      prefer_cpu    <= 1'b1;
      cpu_write     <= 1'b0;
      cpu_addr      <= 16'h0000;
      cpu_wdata     <= RESET_BYTE;
      proc_latch    <= RESET_BYTE;
      fetch_data_out <= RESET_BYTE;
      refresh_count <= RESET_BYTE;
    end else if (clk_en_in) begin
      mem_state <= next_mem_state;
      if (mem_go) begin
        mem_busy  <= 1'b1;
        cpu_write <= mem_wr_in;
        cpu_addr  <= mem_addr_in;
        cpu_wdata <= host_data_in;
      end
      if (mem_state == VGR_IDLE && next_mem_state == VGR_ADDR) begin
        // Alternate owners when both wait
        grant_cpu  <= (mem_busy || mem_go) && (prefer_cpu || !disp_fetch_req_in);
        prefer_cpu <= !((mem_busy || mem_go) && (prefer_cpu || !disp_fetch_req_in));
      end
      if (mem_state == VGR_DATA) begin
        if (grant_cpu && !cpu_write) begin
          proc_latch <= md_in;
        end
        if (!grant_cpu) begin
          fetch_data_out <= md_in;
        end
      end
      if (mem_state == VGR_DONE) begin
        mem_busy <= 1'b0;
      end
      if (!vdisp_en_in && mem_state == VGR_FETCH) begin
        refresh_count <= refresh_count + REFRESH_STEP;
      end
    end
  end

  // Strobes and shared bus
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ras_n_out      <= 4'hF;
      cas_n_out      <= 1'b1;
      we_n_out       <= 1'b1;
      oe_n_out       <= 1'b1;
      md_out         <= RESET_BYTE;
      md_oe_out      <= 1'b0;
      host_ready_out <= 1'b1;
    end else if (clk_en_in) begin
      // Ready returns with the read byte, not a cycle ahead of it
      host_ready_out <= !(mem_busy || mem_go) || mem_state == VGR_DONE;
      case (next_mem_state)
        VGR_ADDR: begin
          ras_n_out <= 4'h0;
          cas_n_out <= 1'b0;
          we_n_out  <= 1'b1;
          oe_n_out  <= 1'b1;
          md_oe_out <= 1'b1;
          // Refresh count replaces display address while blanked
          // A fresh request is not latched yet, so take its address from the pins
          md_out <= (mem_busy || mem_go) && (prefer_cpu || !disp_fetch_req_in) ?
                    (mem_go ? mem_addr_in[7:0] : cpu_addr[7:0]) :
                    (vdisp_en_in ? disp_addr_in[7:0] : refresh_count);
        end
        VGR_DATA: begin
          we_n_out  <= !(grant_cpu && cpu_write);
          oe_n_out  <= grant_cpu && cpu_write;
          md_oe_out <= grant_cpu && cpu_write;
          md_out    <= cpu_wdata;
        end
        default: begin
          ras_n_out <= 4'hF;
          cas_n_out <= 1'b1;
          we_n_out  <= 1'b1;
          oe_n_out  <= 1'b1;
          md_oe_out <= 1'b0;
        end
      endcase
    end
  end

  property p_misc_read;
    clk_en_in && rd_go && hit(io_addr_in, PORT_MISC_RD) |=> host_data_out == $past(misc_output_control);
  endproperty
  a_misc_read: assert property (p_misc_read) else $error("misc readback wrong");
  property p_irq_flag; clk_en_in && retrace_event_in |=> irq_pend; endproperty
  a_irq_flag: assert property (p_irq_flag) else $error("retrace flag lost");
  property p_nmi; clk_en_in && wr_go && trap_hit |=> !nmi_n_out; endproperty
  a_nmi: assert property (p_nmi) else $error("trap did not raise nmi");
  property p_memen; !misc_output_control[MISC_MEM_EN] |-> !mem_go; endproperty
  a_memen: assert property (p_memen) else $error("memory access while disabled");
  property p_vsize;
    clk_en_in |=> vsize_out == $past(misc_output_control[MISC_VPOL:MISC_HPOL]);
  endproperty
  a_vsize: assert property (p_vsize) else $error("vertical size mismatch");
  property p_vsync; clk_en_in && feature_ctl[FEAT_VSYNC_OR] && vdisp_en_in |=> vsync_out; endproperty
  a_vsync: assert property (p_vsync) else $error("vsync not ored");
  property p_dec; !dec_en |-> !rd_go && !wr_go; endproperty
  a_dec: assert property (p_dec) else $error("decode while disabled");
  property p_cycle;
    clk_en_in && mem_state == VGR_IDLE && next_mem_state == VGR_ADDR |=> ras_n_out == 4'h0;
  endproperty
  a_cycle: assert property (p_cycle) else $error("row strobes missing");
  c_mem_wr: cover property (@(posedge clock_in) mem_state == VGR_DONE && cpu_write);
  c_fetch:  cover property (@(posedge clock_in) mem_state == VGR_FETCH);
  c_trap:   cover property (@(posedge clock_in) !nmi_n_out);
endmodule : vgr_top

// ---- vgr_mem_model.sv ----
// Display memory model on the far side of the multiplexed memory bus
`timescale 1ns/10ps
module vgr_mem_model (
  input  wire logic       clock_in,
  input  wire logic       cas_n_in,
  input  wire logic       we_n_in,
  input  wire logic       oe_n_in,
  input  wire logic [7:0] md_in,
  output logic      [7:0] md_out
);
  logic [7:0] mem [256];
  logic [7:0] row  = 8'h00;
  logic [7:0] last = 8'h00;
  // Address phase precedes data, so latch it while no data strobe is low
  always_ff @(posedge clock_in) begin
    if (!cas_n_in && we_n_in && oe_n_in) row <= md_in;
    if (!cas_n_in && !we_n_in) mem[row] <= md_in;
    if (!oe_n_in) last <= md_out;
  end
  // Released bus shows the inverse, so a stale byte never passes for data
  assign md_out = !oe_n_in ? mem[row] : ~last;
endmodule : vgr_mem_model

// ---- vgr_top_tb.sv ----
// Self-checking bench for the general register block
`timescale 1ns/10ps
module vgr_top_tb;
  import vgr_pkg::*;
  localparam logic [15:0] ST1 = {PORT_COLR_BASE[15:4], OFS_STAT1};
  logic clock_in = 1'b0, rst_n_in = 1'b0, clk_en_in = 1'b1;
  logic io_rd_in = 1'b0, io_wr_in = 1'b0, mem_rd_in = 1'b0, mem_wr_in = 1'b0;
  logic sense_in = 1'b0, vretrace_in = 1'b0, hretrace_in = 1'b0, vdisp_en_in = 1'b1;
  logic vsync_raw_in = 1'b0, retrace_event_in = 1'b0, retrace_clear_in = 1'b0;
  logic disp_fetch_req_in = 1'b0;
  logic [15:0] io_addr_in = '0, mem_addr_in = '0, disp_addr_in = '0;
  logic [7:0]  host_data_in = '0, color_in = '0, scan_line_in = '0;
  logic [7:0]  md_in, host_data_out, md_out, fetch_data_out, rd;
  logic        host_ready_out, nmi_n_out, dir_to_host_out, cas_n_out, we_n_out, oe_n_out;
  logic        md_oe_out, pal_rd_n_out, pal_wr_n_out, timing_sel_out, page_hi_out;
  logic        vsync_out, retrace_irq_n_out, dr, lo;
  logic [3:0]  ras_n_out, pan_out;
  logic [1:0]  vsize_out;
  logic [2:0]  clk_sel_out;
  int          n_mismatch = 0, compares = 0, npr, npw, nnmi, nras;

  vgr_top i_dut (.clock_in, .rst_n_in, .clk_en_in, .io_addr_in, .io_rd_in, .io_wr_in,
    .mem_rd_in, .mem_wr_in, .mem_addr_in, .host_data_in, .sense_in, .vretrace_in,
    .hretrace_in, .vdisp_en_in, .vsync_raw_in, .retrace_event_in, .retrace_clear_in,
    .color_in, .scan_line_in, .disp_addr_in, .disp_fetch_req_in, .md_in, .host_data_out,
    .host_ready_out, .nmi_n_out, .dir_to_host_out, .ras_n_out, .cas_n_out, .we_n_out,
    .oe_n_out, .md_out, .md_oe_out, .pal_rd_n_out, .pal_wr_n_out, .timing_sel_out,
    .vsize_out, .page_hi_out, .clk_sel_out, .vsync_out, .retrace_irq_n_out, .pan_out,
    .fetch_data_out);
  vgr_mem_model i_mem (.clock_in, .cas_n_in(cas_n_out), .we_n_in(we_n_out),
    .oe_n_in(oe_n_out), .md_in(md_out), .md_out(md_in));

  always #12.5 clock_in = ~clock_in;
  always @(posedge clock_in) begin
    npr += int'(pal_rd_n_out === 1'b0);
    npw += int'(pal_wr_n_out === 1'b0);
    nnmi += int'(nmi_n_out === 1'b0);
    nras += int'(ras_n_out !== 4'hF);
  end

  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  // Strobe drops one cycle before the next access may start
  task automatic io(input logic [15:0] a, input logic w, input logic [7:0] d);
    @(posedge clock_in);
    io_addr_in <= a; host_data_in <= d; io_wr_in <= w; io_rd_in <= !w;
    repeat (2) @(posedge clock_in);
    io_wr_in <= 1'b0; io_rd_in <= 1'b0;
    #1 rd = host_data_out;
    dr = dir_to_host_out;
    @(posedge clock_in);
  endtask : io
  // Request is a level, so it must be gone before the edge after ready returns
  task automatic mem(input logic w, input logic [15:0] a, input logic [7:0] d);
    lo = 1'b0;
    @(posedge clock_in);
    mem_wr_in <= w; mem_rd_in <= !w; mem_addr_in <= a; host_data_in <= d;
    for (int i = 0; i < 12; i++) begin
      @(posedge clock_in);
      #1 if (!host_ready_out) lo = 1'b1;
      else if (lo) break;
    end
    rd = host_data_out;
    mem_wr_in <= 1'b0; mem_rd_in <= 1'b0;
    @(posedge clock_in);
  endtask : mem
  // One-cycle pulse: 0 retrace event, 1 retrace clear, else display fetch request
  task automatic pulse(input logic [1:0] k);
    @(posedge clock_in);
    case (k)
      2'd0:    retrace_event_in <= 1'b1;
      2'd1:    retrace_clear_in <= 1'b1;
      default: disp_fetch_req_in <= 1'b1;
    endcase
    @(posedge clock_in);
    retrace_event_in <= 1'b0;
    retrace_clear_in <= 1'b0;
    disp_fetch_req_in <= 1'b0;
    repeat (4) @(posedge clock_in);
  endtask : pulse

  task automatic t_reset;
    io(PORT_MISC_RD, 0, 0);
    chk(rd, RESET_BYTE);
    chk(retrace_irq_n_out, 1);
  endtask : t_reset
  task automatic t_misc;
    logic [2:0] c;
    io(PORT_EXT_IDX, 1, EXT_IDX_CLK);
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      io(PORT_EXT_DATA, 1, {7'h00, c[2]});
      io(PORT_MISC_WR, 1, {c[1:0], c[2], 1'b0, c[1:0], 2'b11});
      chk(dr, 0);
      io(PORT_MISC_RD, 0, 0);
      chk(dr, 1);
      chk(rd, {c[1:0], c[2], 1'b0, c[1:0], 2'b11});
      chk(vsize_out, c[1:0]);
      chk(page_hi_out, c[2]);
      chk(clk_sel_out, c);
    end
  endtask : t_misc
  task automatic t_status0;
    sense_in <= 1'b1;
    pulse(2'd0);
    io(PORT_STAT0, 0, 0);
    chk(rd & 8'h90, 8'h90);
    chk(retrace_irq_n_out, 0);
    sense_in <= 1'b0;
    pulse(2'd1);
    io(PORT_STAT0, 0, 0);
    chk(rd & 8'h90, 8'h00);
  endtask : t_status0
  task automatic t_status1;
    vretrace_in <= 1'b1; hretrace_in <= 1'b1; color_in <= 8'h05;
    io(ST1, 0, 0);
    chk(rd & 8'h39, 8'h39);
    vretrace_in <= 1'b0; color_in <= 8'h01;
    io(ST1, 0, 0);
    chk(rd & 8'h39, 8'h11);
    hretrace_in <= 1'b0;
    io(ST1, 0, 0);
    chk(rd & 8'h09, 8'h00);
  endtask : t_status1
  task automatic t_pal_nmi;
    npr = 0; npw = 0; nnmi = 0;
    io(PORT_PAL_WR_IDX, 1, 8'h3C);
    chk(8'(npw), 1);
    io(PORT_PAL_RD_IDX, 0, 0);
    chk(8'(npr), 1);
    chk(8'(nnmi), 0);
    io(TRAP_LO, 1, 8'h00);
    chk(8'(nnmi), 1);
  endtask : t_pal_nmi
  task automatic t_mem;
    nras = 0;
    mem(1, 16'h0042, 8'hA5);
    chk(lo, 1);
    mem(0, 16'h0042, 8'h00);
    chk(rd, 8'hA5);
    chk(8'(nras > 0), 1);
    io(PORT_MISC_WR, 1, 8'hED);
    nras = 0;
    mem(1, 16'h0042, 8'h5A);
    chk(lo, 0);
    chk(8'(nras), 0);
    io(PORT_MISC_WR, 1, 8'hEF);
  endtask : t_mem
  task automatic t_subsys;
    io(PORT_SUBSYS, 1, 8'h00);
    io(PORT_MISC_WR, 1, 8'h00);
    io(PORT_SUBSYS, 1, 8'h01);
    io(PORT_MISC_RD, 0, 0);
    chk(rd, 8'hEF);
    io(16'h0300, 0, 0);
    chk(rd, 8'h00);
  endtask : t_subsys
  task automatic t_vsync;
    io(ST1, 1, 8'h08);
    vdisp_en_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    #1 chk(vsync_out, 1);
    io(ST1, 1, 8'h00);
    repeat (3) @(posedge clock_in);
    #1 chk(vsync_out, 0);
  endtask : t_vsync
  // Blanked fetch must use the refresh count, not the display address
  task automatic t_fetch;
    mem(1, 16'h0000, 8'h3C);
    vdisp_en_in <= 1'b0;
    disp_addr_in <= 16'h0055;
    pulse(2'd2);
    chk(fetch_data_out, 8'h3C);
    vdisp_en_in <= 1'b1;
  endtask : t_fetch
  task automatic t_split;
    io(PORT_EXT_IDX, 1, EXT_IDX_LINE);
    io(PORT_EXT_DATA, 1, 8'h10);
    io(PORT_EXT_IDX, 1, EXT_IDX_PAN);
    io(PORT_EXT_DATA, 1, 8'h05);
    scan_line_in <= 8'h08;
    repeat (2) @(posedge clock_in);
    #1 chk(pan_out, 8'h05);
    scan_line_in <= 8'h20;
    repeat (2) @(posedge clock_in);
    #1 chk(pan_out, 8'h00);
  endtask : t_split

  task automatic end_of_test;
    $display("compares=%0d mismatches=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  initial begin
    repeat (4) @(posedge clock_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_misc();
    t_status0();
    t_status1();
    t_pal_nmi();
    t_mem();
    t_subsys();
    t_vsync();
    t_fetch();
    t_split();
    end_of_test();
  end
  // Whole run needs well under a thousand cycles
  initial begin
    #100000;
    n_mismatch++;
    end_of_test();
  end
endmodule : vgr_top_tb
